// ### src/pin_filter.sv
`timescale 1ns/1ps
module pin_filter #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, level_reg;
  logic [W-1:0] level_next;

  // A change counts only once the second and third stage agree
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg    <= '0;
      s2_reg    <= '0;
      s3_reg    <= '0;
      level_reg <= '0;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule // pin_filter

// ### src/spi_resp_frame.sv
`timescale 1ns/1ps
module spi_resp_frame
  import spi_resp_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Link pins
  input  wire logic        sclk,
  input  wire logic        ss_n,
  input  wire logic        mosi,
  output logic             miso_o,
  output logic             miso_oe,
  // Register map read port
  output logic [6:0]       register_word_address,
  input  wire logic [15:0] reg_rd_data,
  // Sensor data and status
  input  wire logic        sample_avail,
  input  wire logic [11:0] sample_value_field,
  input  wire logic [3:0]  sample_res,
  input  wire logic [1:0]  basic_status_field,
  input  wire logic [1:0]  detailed_status_field,
  // Error flags for the current frame
  input  wire logic        spi_error,
  input  wire logic        miso_error,
  // Received command
  output logic [31:0]      cmd_word,
  output logic             cmd_valid
);
  typedef enum logic [0:0] {IDLE, SHIFT} frame_state_e;

  logic [2:0]   pins;
  logic         sclk_f, ss_f, mosi_f;
  logic         sclk_d_reg, ss_d_reg;
  frame_state_e state_reg, state_next;
  logic [5:0]   cnt_reg, cnt_next;
  logic [31:0]  rx_reg, rx_next;
  logic [31:0]  tx_reg, tx_next;
  logic [31:0]  resp_reg, resp_next;
  logic [6:0]   addr_reg, addr_next;
  logic         miso_reg, miso_next;
  logic         oe_reg, oe_next;
  logic [31:0]  cmdw_reg, cmdw_next;
  logic         cmdv_reg, cmdv_next;
  logic         sclk_rise, sclk_fall, ss_fall, ss_rise;
  logic         frame_end, frame_err;
  logic [3:0]   cmd;
  logic [23:0]  body;

  // Select enters inverted so the zero reset of the filter reads as deselected,
  // otherwise a false select fall would follow every reset
  pin_filter #(.W(3)) u_pins (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  ({sclk, ~ss_n, mosi}),
    .level   (pins)
  );
  assign sclk_f = pins[2];
  assign ss_f   = ~pins[1];
  assign mosi_f = pins[0];

  // Select is active low; clock idles low so edges only count inside a frame
  assign sclk_rise = sclk_f & ~sclk_d_reg & (state_reg == SHIFT);
  assign sclk_fall = ~sclk_f & sclk_d_reg & (state_reg == SHIFT);
  assign ss_fall   = ~ss_f & ss_d_reg;
  assign ss_rise   = ss_f & ~ss_d_reg & (state_reg == SHIFT);
  assign frame_end = ss_rise;
  assign cmd       = rx_reg[CMD_MSB:CMD_LSB];
  // A short or long frame counts as a protocol error
  assign frame_err = spi_error | miso_error | (cnt_reg != FRAME_CNT);

  always_comb begin
    body      = '0;
    resp_next = resp_reg;
    if (frame_end) begin
      if (cmd == CMD_REG_READ) begin
        if (frame_err) begin
          body = {ECHO_REG_READ, ST_ERROR, 16'h0000, detailed_status_field};
        end else begin
          // Register data captured right at the select rise
          body = {ECHO_REG_READ, basic_status_field, 2'b00, reg_rd_data};
        end
      end else if (cmd[0] && sample_avail) begin
        body = {cmd[0], cmd[3:1], frame_err ? ST_ERROR : basic_status_field,
                sample_value_field, sample_res, detailed_status_field};
      end else begin
        // Zero command, writes and reserved codes get the no-data error reply
        body = {CMD_NONE, ST_ERROR, 16'h0000, detailed_status_field};
      end
      resp_next = {body, crc8(body)};
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rx_next    = rx_reg;
    tx_next    = tx_reg;
    addr_next  = addr_reg;
    miso_next  = miso_reg;
    oe_next    = oe_reg;
    cmdw_next  = cmdw_reg;
    cmdv_next  = 1'b0;
    case (state_reg)
      IDLE: begin
        if (ss_fall) begin
          // Reply prepared last frame goes out now
          state_next = SHIFT;
          cnt_next   = '0;
          tx_next    = resp_reg;
          miso_next  = resp_reg[FRAME_BITS-1];
          oe_next    = 1'b1;
        end
      end
      SHIFT: begin
        if (ss_rise) begin
          state_next = IDLE;
          oe_next    = 1'b0;
          miso_next  = 1'b0;
          cmdw_next  = rx_reg;
          cmdv_next  = (cnt_reg == FRAME_CNT);
        end else begin
          if (sclk_rise) begin
            rx_next  = {rx_reg[30:0], mosi_f};
            // Stops one past a full frame so a long frame still reads as bad
            cnt_next = (cnt_reg > FRAME_CNT) ? cnt_reg : cnt_reg + 6'h01;
            // Address settles mid-frame so the register port is stable by the select rise
            if (cnt_reg == ADDR_DONE_CNT - 6'h01) begin
              addr_next = rx_next[6:0];
            end
          end
          if (sclk_fall) begin
            tx_next   = {tx_reg[30:0], 1'b0};
            miso_next = tx_reg[30];
          end
        end
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg  <= IDLE;
      cnt_reg    <= '0;
      rx_reg     <= '0;
      tx_reg     <= '0;
      resp_reg   <= RESP_RESET;
      addr_reg   <= '0;
      miso_reg   <= 1'b0;
      oe_reg     <= 1'b0;
      cmdw_reg   <= '0;
      cmdv_reg   <= 1'b0;
      sclk_d_reg <= 1'b0;
      ss_d_reg   <= 1'b1;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      rx_reg     <= rx_next;
      tx_reg     <= tx_next;
      resp_reg   <= resp_next;
      addr_reg   <= addr_next;
      miso_reg   <= miso_next;
      oe_reg     <= oe_next;
      cmdw_reg   <= cmdw_next;
      cmdv_reg   <= cmdv_next;
      sclk_d_reg <= sclk_f;
      ss_d_reg   <= ss_f;
    end
  end

  assign miso_o                = miso_reg;
  assign miso_oe               = oe_reg;
  assign register_word_address = addr_reg;
  assign cmd_word              = cmdw_reg;
  assign cmd_valid             = cmdv_reg;

  chk_word_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && cnt_reg == FRAME_CNT |-> addr_reg == rx_reg[ADDR_MSB:ADDR_LSB])
    else $error("word address does not match received bits 23:17");
  chk_next_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == IDLE && ss_fall |=> tx_reg == $past(resp_reg) && oe_reg)
    else $error("reply not loaded at frame start");
  chk_err_spi: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && cmd == CMD_REG_READ && spi_error |=> resp_reg[27:26] == ST_ERROR)
    else $error("protocol error not reported");
  chk_err_miso: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && cmd == CMD_REG_READ && miso_error |=> resp_reg[27:26] == ST_ERROR)
    else $error("output mismatch not reported");
  chk_err_body: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && frame_err && cmd == CMD_REG_READ
    |=> resp_reg[25:10] == 16'h0000 && resp_reg[9:8] == $past(detailed_status_field))
    else $error("error reply body wrong");
  chk_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && !frame_err && cmd == CMD_REG_READ
    |=> resp_reg[23:8] == $past(reg_rd_data) && resp_reg[25:24] == 2'b00)
    else $error("register data not captured at select rise");
  chk_read_echo: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && cmd == CMD_REG_READ |=> resp_reg[31:28] == ECHO_REG_READ)
    else $error("read echo code wrong");
  chk_reply_crc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end |=> resp_reg[7:0] == crc8(resp_reg[31:8]))
    else $error("reply CRC wrong");
  chk_sample_fail: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && frame_err && cmd[0] && sample_avail
    |=> resp_reg[27:26] == ST_ERROR && resp_reg[25:14] == $past(sample_value_field))
    else $error("failed sensor reply lost its sample");
  chk_no_sample: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && cmd[0] && !sample_avail |=> resp_reg[31:10] == {CMD_NONE, ST_ERROR, 16'h0})
    else $error("no-sample reply not zeroed");
  chk_msb_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == SHIFT && sclk_fall && !ss_rise |=> miso_reg == $past(tx_reg[30]))
    else $error("output bit order wrong");
  chk_length_err: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && cnt_reg != FRAME_CNT |=> !cmd_valid && resp_reg[27:26] == ST_ERROR)
    else $error("bad frame length not flagged");
  chk_sensor_reply: assert property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && !frame_err && cmd[0] && sample_avail
    |=> resp_reg[31] == $past(cmd[0]) && resp_reg[30:28] == $past(cmd[3:1])
        && resp_reg[27:26] == $past(basic_status_field)
        && resp_reg[9:8] == $past(detailed_status_field))
    else $error("sensor reply fields wrong");
  chk_idle_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_reg == IDLE |-> !miso_oe)
    else $error("output driven outside a frame");
endmodule // spi_resp_frame

// ### src/spi_resp_pkg.sv
package spi_resp_pkg;
  localparam int          FRAME_BITS    = 32;
  localparam logic [5:0]  FRAME_CNT     = 6'h20;
  localparam logic [5:0]  ADDR_DONE_CNT = 6'h0F;
  localparam logic [3:0]  CMD_NONE      = 4'h0;
  localparam logic [3:0]  CMD_REG_READ  = 4'hC;
  localparam logic [3:0]  ECHO_REG_READ = 4'h6;
  localparam logic [1:0]  ST_ERROR      = 2'h3;
  localparam int          CMD_MSB       = 31;
  localparam int          CMD_LSB       = 28;
  localparam int          ADDR_MSB      = 23;
  localparam int          ADDR_LSB      = 17;
  localparam logic [7:0]  CRC_POLY      = 8'h2F;
  localparam logic [7:0]  CRC_SEED      = 8'hFF;
  localparam logic [31:0] RESP_RESET    = 32'h0000_0000;

  // CRC over the 24 upper reply bits, MSB first
  function automatic logic [7:0] crc8(input logic [23:0] data);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = (c[7] ^ data[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction
endpackage

// ### tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  // Clock
  input  wire logic ref_clk,
  // Link pins
  input  wire logic miso,
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // High 2 cycles, low 6: the filtered fall moves the reply bit 5 cycles later,
  // one cycle ahead of the next rise; a symmetric clock would read each bit late
  // Bits beyond 32 are sent as zero and not stored
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    rx = '0;
    @(posedge ref_clk);
    ss_n <= 1'b0;
    mosi <= tx[31];
    wait_clk(8);
    for (int i = 31; i > 31 - nb; i--) begin
      @(posedge ref_clk);
      sclk  <= 1'b1;
      if (i >= 0) rx[i] = miso;
      wait_clk(2);
      sclk <= 1'b0;
      mosi <= (i > 0) ? tx[i-1] : 1'b0;
      wait_clk(5);
    end
    @(posedge ref_clk);
    ss_n <= 1'b1;
  endtask
endmodule // spi_host_model

// ### tb/spi_resp_frame_bench.sv
`timescale 1ns/1ps
module spi_resp_frame_bench
  import spi_resp_pkg::*;
;
  localparam logic [1:0]  BST = 2'h1;
  localparam logic [1:0]  DST = 2'h2;
  localparam logic [11:0] SMP = 12'hA5C;
  localparam logic [3:0]  RES = 4'h9;
  localparam logic [31:0] RD2B = {CMD_REG_READ, 4'h0, 8'h2B, 16'h0};
  logic        ref_clk, rst_n, sclk, ss_n, mosi, miso_o, miso_oe, miso_w, cmd_valid;
  logic        sample_avail, spi_error, miso_error;
  logic        miso_last = 1'b0;
  logic [6:0]  register_word_address;
  logic [15:0] reg_rd_data;
  logic [31:0] cmd_word, rx;
  logic [7:0]  salt;
  int          bad_count = 0;
  int          total_checks = 0;
  int          frame_bits = 32;

  // Released line shows the inverse of the last bit, never a stale copy
  assign miso_w = miso_oe ? miso_o : ~miso_last;
  always @(posedge ref_clk) if (miso_oe) miso_last <= miso_o;
  assign reg_rd_data = {salt ^ {1'b1, register_word_address}, salt ^ {1'b0, register_word_address}};

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  spi_resp_frame u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
    .register_word_address(register_word_address), .reg_rd_data(reg_rd_data),
    .sample_avail(sample_avail), .sample_value_field(SMP), .sample_res(RES),
    .basic_status_field(BST), .detailed_status_field(DST), .spi_error(spi_error),
    .miso_error(miso_error), .cmd_word(cmd_word), .cmd_valid(cmd_valid));

  spi_host_model u_host (.ref_clk(ref_clk), .miso(miso_w), .sclk(sclk), .ss_n(ss_n),
    .mosi(mosi));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] with_crc(input logic [23:0] u);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ u[i]) ? CRC_POLY : 8'h00);
    return {u, c};
  endfunction

  task automatic frame(input logic [31:0] tx, input logic se, me, sa, input logic [31:0] exp);
    int n;
    @(posedge ref_clk);
    spi_error    <= se;
    miso_error   <= me;
    sample_avail <= sa;
    u_host.xfer(tx, frame_bits, rx);
    check(rx, exp);
    n = 0;
    while (cmd_valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, cmd_valid}, {31'h0, frame_bits == 32});
    check(cmd_word, tx << (frame_bits - 32));
    check({31'h0, miso_oe}, 32'h0);
    repeat (6) @(posedge ref_clk);
    $display("test done: frame %h", tx);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    spi_error = 1'b0;
    miso_error = 1'b0;
    sample_avail = 1'b1;
    salt = 8'h00;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    frame(RD2B, 0, 0, 1, RESP_RESET);
    check({25'h0, register_word_address}, 32'h15);
    // Contents change after capture; the reply must keep the old ones
    salt <= 8'h3C;
    frame({CMD_REG_READ, 4'h0, 8'h54, 16'h0}, 0, 0, 1,
      with_crc({ECHO_REG_READ, BST, 2'b00, 8'h95, 8'h15}));
    frame(RD2B, 1, 0, 1, with_crc({ECHO_REG_READ, BST, 2'b00, 8'h96, 8'h16}));
    frame(32'h1000_0000, 0, 0, 1, with_crc({ECHO_REG_READ, ST_ERROR, 16'h0, DST}));
    frame(RD2B, 0, 1, 1, with_crc({4'h8, BST, SMP, RES, DST}));
    frame(32'hF000_0000, 1, 0, 1, with_crc({ECHO_REG_READ, ST_ERROR, 16'h0, DST}));
    frame(32'hE000_0000, 0, 0, 1, with_crc({4'hF, ST_ERROR, SMP, RES, DST}));
    frame(32'h3000_0000, 0, 0, 0, with_crc({CMD_NONE, ST_ERROR, 16'h0, DST}));
    frame(RD2B, 0, 0, 0, with_crc({CMD_NONE, ST_ERROR, 16'h0, DST}));
    // One bit too many must spoil an otherwise valid read
    frame_bits = 33;
    frame(32'h6000_0000, 0, 0, 0, with_crc({ECHO_REG_READ, BST, 2'b00, 8'hA9, 8'h29}));
    frame_bits = 32;
    frame(RD2B, 0, 0, 1, with_crc({ECHO_REG_READ, ST_ERROR, 16'h0, DST}));
    print_verdict();
  end

  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
endmodule // spi_resp_frame_bench
